// ==== hbp_cfg.svh ====
// Constants for the host bus port pin logic
`ifndef HBP_CFG_SVH
`define HBP_CFG_SVH
`define HBP_MCR_IRQ_EN_BIT 3
`define HBP_MCR_IR_SEL_BIT 6
`define HBP_MCR_RESET 8'h00
`define HBP_ADDR_W 3
`define HBP_DATA_W 8
`endif

// ==== hbp_pkg.sv ====
// Types for the host bus port pin logic
package hbp_pkg;
    typedef enum logic [1:0] {
        HBP_IDLE = 2'b00,
        HBP_READ = 2'b01,
        HBP_WRITE = 2'b10
    } hbp_state_type;
endpackage : hbp_pkg

// ==== hbp_port.sv ====
// Host bus port: strobe decode, register access, interrupt and transmit pins
`include "hbp_cfg.svh"
module hbp_port #(
    parameter int ADDR_W = `HBP_ADDR_W,
    parameter int DATA_W = `HBP_DATA_W
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_bus_style,
    input wire logic i_chip_sel_n,
    input wire logic i_read_strobe_n,
    input wire logic i_write_strobe_n,
    input wire logic [ADDR_W-1:0] i_reg_select_lines,
    input wire logic [DATA_W-1:0] i_host_data_lines,
    input wire logic i_irq_pending,
    input wire logic i_tx_active,
    input wire logic i_tx_serial,
    input wire logic i_tx_infrared,
    input wire logic [DATA_W-1:0] i_rd_data,
    input wire logic [DATA_W-1:0] i_modem_control_reg,
    output logic [ADDR_W-1:0] o_reg_addr,
    output logic o_rd_pulse,
    output logic o_wr_pulse,
    output logic [DATA_W-1:0] o_wr_data,
    output logic [DATA_W-1:0] o_host_data_lines,
    output logic o_host_data_oe,
    output logic o_irq_out,
    output logic o_irq_oe,
    output logic o_tx
);
    import hbp_pkg::*;

    // Widths are fixed by the reset constants and the decode below, so
    // any other size is refused while the design is built
    if (ADDR_W != `HBP_ADDR_W || DATA_W != `HBP_DATA_W) begin : g_bad_size
        $error("hbp_port supports three select lines and eight data bits");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        hbp_state_type st;
        logic rd_n;
        logic wr_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] rdat;
        logic [DATA_W-1:0] wdat;
        logic rd_p;
        logic wr_p;
        logic oe;
        logic tx;
    } hbp_regs_type;

    hbp_regs_type s_q, s_d;
    logic ir_sel, irq_en;
    logic start_rd, start_wr, end_acc;

    assign ir_sel = i_modem_control_reg[`HBP_MCR_IR_SEL_BIT];
    assign irq_en = i_modem_control_reg[`HBP_MCR_IRQ_EN_BIT];

    // Strobe style uses separate falling strobes; direction style uses the
    // low level of chip select while idle, the direction sampled at that edge.
    always_comb begin
        start_rd = 1'b0;
        start_wr = 1'b0;
        end_acc = 1'b0;
        if (i_bus_style) begin
            start_rd = !i_chip_sel_n && s_q.rd_n && !i_read_strobe_n;
            start_wr = !i_chip_sel_n && s_q.wr_n && !i_write_strobe_n;
            end_acc = (s_q.st == HBP_READ) ? i_read_strobe_n
                                           : i_write_strobe_n;
        end else begin
            start_rd = !i_chip_sel_n && i_write_strobe_n;
            start_wr = !i_chip_sel_n && !i_write_strobe_n;
            end_acc = i_chip_sel_n;
        end
        end_acc = end_acc || i_chip_sel_n;
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.rd_n = i_read_strobe_n;
        s_d.wr_n = i_write_strobe_n;
        s_d.rd_p = 1'b0;
        s_d.wr_p = 1'b0;
        case (s_q.st)
            HBP_IDLE: begin
                s_d.oe = 1'b0;
                if (start_rd) begin
                    s_d.st = HBP_READ;
                    s_d.addr = i_reg_select_lines;
                    s_d.rd_p = 1'b1;
                end else if (start_wr) begin
                    s_d.st = HBP_WRITE;
                    s_d.addr = i_reg_select_lines;
                end
            end
            HBP_READ: begin
                s_d.rdat = i_rd_data;
                s_d.oe = 1'b1;
                if (end_acc) begin
                    s_d.st = HBP_IDLE;
                    s_d.oe = 1'b0;
                end
            end
            HBP_WRITE: begin
                // Data is followed until the closing edge, then loaded
                s_d.wdat = i_host_data_lines;
                if (end_acc) begin
                    s_d.st = HBP_IDLE;
                    s_d.wr_p = 1'b1;
                end
            end
            default: begin
                s_d.st = HBP_IDLE;
                s_d.oe = 1'b0;
            end
        endcase
        // Idle level follows the selected mode
        if (!i_tx_active) begin
            s_d.tx = !ir_sel;
        end else begin
            s_d.tx = ir_sel ? i_tx_infrared : i_tx_serial;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s_q.st <= HBP_IDLE;
            s_q.rd_n <= 1'b1;
            s_q.wr_n <= 1'b1;
            s_q.addr <= '0;
            s_q.rdat <= 8'h00;
            s_q.wdat <= 8'h00;
            s_q.rd_p <= 1'b0;
            s_q.wr_p <= 1'b0;
            s_q.oe <= 1'b0;
            s_q.tx <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign o_reg_addr = s_q.addr;
    assign o_rd_pulse = s_q.rd_p;
    assign o_wr_pulse = s_q.wr_p;
    assign o_wr_data = s_q.wdat;
    assign o_host_data_lines = s_q.rdat;
    assign o_host_data_oe = s_q.oe;
    assign o_tx = s_q.tx;

    // Direction style is open drain, low only, board pull-up returns it high; strobe style drives i_irq_pending while irq_en is set
    assign o_irq_out = i_bus_style ? i_irq_pending : 1'b0;
    assign o_irq_oe = i_bus_style ? irq_en : i_irq_pending;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence rd_start_s;
        !i_chip_sel_n && i_bus_style && s_q.st == HBP_IDLE && start_rd;
    endsequence

    a_read_strobe_start: assert property (@(posedge i_clk)
        disable iff (!i_nrst) rd_start_s |=> o_rd_pulse
        ##1 (o_host_data_oe || $past(end_acc)))
        else $error("read strobe did not start a read");
    a_write_load_rise: assert property (@(posedge i_clk)
        disable iff (!i_nrst) (s_q.st == HBP_WRITE && end_acc)
        |=> o_wr_pulse && o_wr_data == $past(i_host_data_lines))
        else $error("write not loaded at strobe end");
    a_dir_line_sense: assert property (@(posedge i_clk)
        disable iff (!i_nrst) (!i_bus_style && s_q.st == HBP_IDLE
        && !i_chip_sel_n && !i_write_strobe_n) |=> s_q.st == HBP_WRITE)
        else $error("direction low did not start a write");
    a_chip_sel_gate: assert property (@(posedge i_clk)
        disable iff (!i_nrst) i_chip_sel_n |=> !o_rd_pulse
        && s_q.st == HBP_IDLE
        && (!o_wr_pulse || $past(s_q.st) != HBP_IDLE)
        ##1 !o_host_data_oe)
        else $error("access while chip select high");
    a_irq_drive_mode: assert property (@(posedge i_clk)
        disable iff (!i_nrst) i_bus_style |-> o_irq_oe == irq_en
        && o_irq_out == i_irq_pending)
        else $error("interrupt drive mode wrong");
    a_irq_open_drain: assert property (@(posedge i_clk)
        disable iff (!i_nrst) !i_bus_style |-> !o_irq_out
        && o_irq_oe == i_irq_pending)
        else $error("open drain interrupt wrong");
    a_tx_idle_level: assert property (@(posedge i_clk)
        disable iff (!i_nrst) !i_tx_active |=> o_tx == !$past(ir_sel))
        else $error("transmit idle level wrong");
    a_tx_ir_data: assert property (@(posedge i_clk)
        disable iff (!i_nrst) (i_tx_active && ir_sel)
        |=> o_tx == $past(i_tx_infrared))
        else $error("infrared data not on transmit pin");
    a_addr_capture: assert property (@(posedge i_clk)
        disable iff (!i_nrst) (s_q.st == HBP_IDLE && (start_rd || start_wr))
        |=> o_reg_addr == $past(i_reg_select_lines))
        else $error("select lines not captured");
    a_data_oe_read: assert property (@(posedge i_clk)
        disable iff (!i_nrst) o_host_data_oe |-> $past(s_q.st) == HBP_READ)
        else $error("data lines driven outside a read");
endmodule : hbp_port

// ==== hbp_host.sv ====
// Host processor model driving the parallel bus pins
module hbp_host (
    input wire logic i_clk,
    input wire logic i_bus_style,
    input wire logic i_oe,
    input wire logic [7:0] i_dev_data,
    output logic o_cs_n = 1'b1,
    output logic o_rd_n = 1'b1,
    output logic o_wr_n = 1'b1,
    output logic [2:0] o_addr = 3'h0,
    output logic [7:0] o_data = 8'h00
);
    timeunit 1ns;
    timeprecision 1ps;
    // One access; cs high enables it, wr picks write over read
    task automatic access(input logic cs, input logic wr,
                          input logic [2:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        int n;
        n = 0;
        @(posedge i_clk);
        o_cs_n <= !cs;
        o_addr <= a;
        o_data <= d;
        o_rd_n <= wr | !i_bus_style;
        o_wr_n <= !wr;
        repeat (3) @(posedge i_clk);
        while (!wr && i_oe !== 1'b1 && n < 6) begin
            @(posedge i_clk);
            n++;
        end
        q = i_dev_data;
        o_cs_n <= 1'b1;
        o_rd_n <= 1'b1;
        o_wr_n <= 1'b1;
        // Data is held one cycle past the strobes, since the port loads it
        // at the edge that first sees the strobe high; then the lines show
        // the inverse so stale data cannot match
        @(posedge i_clk);
        o_data <= ~d;
        repeat (2) @(posedge i_clk);
    endtask : access
endmodule : hbp_host

// ==== hbp_port_tb.sv ====
// Self-checking bench for the host bus port pin logic
module hbp_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, nrst = 0, sty = 1, irq = 0, txa = 0, txs = 0, txi = 0;
    logic [7:0] modem_control_reg = 8'h00, q, wdc;
    logic [2:0] wac;
    wire cs_n, rd_n, wr_n, oe, rdp, wrp, irqo, irqoe, tx;
    wire irq_pin;
    wire [2:0] ha, ra;
    wire [7:0] hd, hdrv, dd, wd, rdv;
    int err_total = 0, check_count = 0, cyc = 0, nacc = 0;
    hbp_host hbp_host_i (.i_clk(clk), .i_bus_style(sty), .i_oe(oe),
        .i_dev_data(hd), .o_cs_n(cs_n), .o_rd_n(rd_n), .o_wr_n(wr_n),
        .o_addr(ha), .o_data(hdrv));
    hbp_port hbp_port_i (.i_clk(clk), .i_nrst(nrst), .i_bus_style(sty),
        .i_chip_sel_n(cs_n), .i_read_strobe_n(rd_n),
        .i_write_strobe_n(wr_n), .i_reg_select_lines(ha),
        .i_host_data_lines(hd), .i_irq_pending(irq), .i_tx_active(txa),
        .i_tx_serial(txs), .i_tx_infrared(txi), .i_rd_data(rdv),
        .i_modem_control_reg(modem_control_reg), .o_reg_addr(ra), .o_rd_pulse(rdp),
        .o_wr_pulse(wrp), .o_wr_data(wd), .o_host_data_lines(dd),
        .o_host_data_oe(oe), .o_irq_out(irqo), .o_irq_oe(irqoe), .o_tx(tx));
    assign hd = oe ? dd : hdrv;
    // Board pull-up on the open-drain interrupt line
    assign irq_pin = irqoe ? irqo : 1'b1;
    // Core register model: address folded into the byte
    assign rdv = {5'h15, ra};
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (rdp === 1'b1 || wrp === 1'b1) nacc++;
        if (wrp === 1'b1) begin
            wdc <= wd;
            wac <= ra;
        end
        if (cyc == 4000) begin
            err_total++;
            wrap_up();
        end
    end
    task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic t_acc(input logic s, input logic w);
        int n0;
        n0 = nacc;
        sty <= s;
        for (int a = 0; a < 8; a++) begin
            hbp_host_i.access(1'b1, w, a[2:0], {a[2:0], 5'h0a}, q);
            if (w) chk("wdata", {a[2:0], 5'h0a}, wdc);
            if (w) chk("waddr", 8'(a), wac);
            else chk("rdata", {5'h15, a[2:0]}, q);
        end
        chk("oe idle", 8'h00, oe);
        chk("count", 8'(n0 + 8), 8'(nacc));
        hbp_host_i.access(1'b0, w, 3'h3, 8'h55, q);
        chk("no cs", 8'(n0 + 8), 8'(nacc));
        $display("access style %0d write %0d done", s, w);
    endtask : t_acc
    task automatic t_irq;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            {sty, modem_control_reg[3], irq} <= i[2:0];
            @(negedge clk);
            chk("irq", sty ? {irq, modem_control_reg[3]} : {1'b0, irq}, {irqo, irqoe});
            if (!sty) chk("irq pin", {7'h00, !irq}, irq_pin);
        end
        $display("irq done");
    endtask : t_irq
    task automatic t_tx;
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            {modem_control_reg[6], txa, txs, txi} <= i[3:0];
            repeat (3) @(negedge clk);
            chk("tx", modem_control_reg[6] ? txa & txi : !txa | txs, tx);
        end
        $display("tx done");
    endtask : t_tx
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (8) @(posedge clk);
        chk("tx reset", 8'h01, tx);
        chk("oe reset", 8'h00, oe);
        nrst <= 1'b1;
        t_acc(1'b1, 1'b0);
        t_acc(1'b0, 1'b0);
        t_acc(1'b1, 1'b1);
        t_acc(1'b0, 1'b1);
        t_irq();
        t_tx();
        wrap_up();
    end
endmodule : hbp_port_tb
